// file: src/clock_gen_consts.svh
// Contract
// - external mode on first write: input pin is clock or oscillator input per ref select
// - self-clocked or internal mode on first write: both oscillator pins stay unused
// - external mode on first write: output pin carries the oscillator output
// - bit 7 chooses low-power (0) or high-gain (1) oscillator
// - after reset the oscillator runs gain-controlled low-power
// - gain, range and reference bits take one write per reset
// - bit 6 chooses low range, prescale 64, or high range, prescale 1
// - range bit acts only in the two external-reference modes
// - bit 5 chooses external clock (0) or crystal oscillator (1)
// - mode field 4:3 encodes self, internal, bypassed external, engaged external
// - bypassed external request waits for reference ready
// - off mode leaves the mode field unchanged
// - mode write dropped while an earlier one is still in progress
// - first write of 0X blocks later 1X mode writes until reset
// - bit 2 low: oscillator off in off mode unless enable, mode 10, crystal
// - bit 2 high: oscillator kept in off mode with mode 1X and crystal
// - bit 2 ignored when gain and range bits are both set
// - bit 1 low keeps loss-of-clock detection, high disables it
// - after reset the generator is self-clocked with a free-running oscillator
// - mode status 7:6 shows the active mode, lagging a write
`ifndef CLOCK_GEN_CONSTS_SVH
`define CLOCK_GEN_CONSTS_SVH

// register word addresses on the bus
`define CG_ADDR_CONTROL    8'h00
`define CG_ADDR_STATUS     8'h04
// control register fields
`define CG_BIT_HIGH_GAIN   7
`define CG_BIT_RANGE       6
`define CG_BIT_EXT_REF     5
`define CG_MODE_HI         4
`define CG_MODE_LO         3
`define CG_BIT_KEEP_OFF    2
`define CG_BIT_LOSS_OFF    1
// status register fields
`define CG_ST_MODE_HI      7
`define CG_ST_MODE_LO      6
`define CG_ST_REF_KIND     5
`define CG_ST_BUSY         4
`define CG_ST_RESERVED     1
`define CG_ST_FIRST_DONE   0
// reset values
`define CG_CONTROL_RESET   8'h00
// prescale factors of the loop
`define CG_PRESCALE_LOW    7'h40
`define CG_PRESCALE_HIGH   7'h01
// cycles taken to carry a mode change into the loop domain
`define CG_MODE_SYNC_CYCLES 4'h3

`endif

// file: src/clock_gen_pkg.sv
package clock_gen_pkg;

    // clock modes as held in the mode field
    typedef enum logic [1:0] {
        self_clocked_mode      = 2'h0,
        loop_engaged_internal  = 2'h1,
        loop_bypassed_external = 2'h2,
        loop_engaged_external  = 2'h3
    } clock_mode_t;

    // mode sequencer states
    typedef enum logic [2:0] {
        seq_idle  = 3'h1,
        seq_wait  = 3'h2,
        seq_sync  = 3'h4
    } seq_state_t;

    typedef struct packed {
        seq_state_t  state;
        clock_mode_t target;
        clock_mode_t active;
        logic [3:0]  count;
    } seq_regs_t;

    // control register image
    typedef struct packed {
        logic        high_gain_select;
        logic        range_high;
        logic        ext_ref_select;
        clock_mode_t clock_mode_select;
        logic        osc_keep_in_off;
        logic        clock_loss_detect_off;
    } ctrl_fields_t;

    typedef struct packed {
        logic         ack;
        logic [7:0]   rdata;
        ctrl_fields_t ctrl;
        logic         first_done;
        logic         pins_reserved;
        logic         req;
        clock_mode_t  req_mode;
        logic         osc_enable;
        logic         osc_out;
        logic         osc_oe;
        logic         ref_clk_out;
        logic         loss_detect_en;
        logic         range_eff;
        logic [6:0]   prescale;
        logic         free_run;
        logic         high_gain;
    } ctl_regs_t;

endpackage

// file: src/clock_gen_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module clock_gen_sync2 #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_regs_t;

    sync_regs_t r;
    sync_regs_t next_r;

    // -------------------------------------------------------------
    // two stages per bit; only the second stage is read outside
    // -------------------------------------------------------------
    always_comb begin
        next_r = r;
        for (int i = 0; i < WIDTH; i++) begin
            next_r.first[i]  = async_i[i];
            next_r.second[i] = r.first[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign sync_o = r.second;

endmodule // clock_gen_sync2

`default_nettype wire

// file: src/clock_gen_mode_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_consts.svh"

module clock_gen_mode_seq (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       req_i,
    input  wire clock_gen_pkg::clock_mode_t mode_i,
    input  wire logic                       ready_i,
    output logic                            busy_o,
    output clock_gen_pkg::clock_mode_t      active_o
);

    clock_gen_pkg::seq_regs_t r;
    clock_gen_pkg::seq_regs_t next_r;

    // -------------------------------------------------------------
    // a request runs through the crossing delay before it shows
    // -------------------------------------------------------------
    always_comb begin
        next_r = r;
        unique case (r.state)
            clock_gen_pkg::seq_idle: begin
                if (req_i) begin
                    next_r.target = mode_i;
                    next_r.count  = `CG_MODE_SYNC_CYCLES;
                    if (mode_i == clock_gen_pkg::loop_bypassed_external) begin
                        next_r.state = clock_gen_pkg::seq_wait;
                    end else begin
                        next_r.state = clock_gen_pkg::seq_sync;
                    end
                end
            end
            clock_gen_pkg::seq_wait: begin
                // bypass only once the reference is proven running
                if (ready_i) begin
                    next_r.state = clock_gen_pkg::seq_sync;
                end
            end
            clock_gen_pkg::seq_sync: begin
                if (r.count == 4'h1) begin
                    next_r.active = r.target;
                    next_r.state  = clock_gen_pkg::seq_idle;
                end else begin
                    next_r.count = r.count - 4'h1;
                end
            end
            default: begin
                next_r.state = clock_gen_pkg::seq_idle;
            end
        endcase
    end

    // reset lands in self-clocked mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.state  <= clock_gen_pkg::seq_idle;
            r.target <= clock_gen_pkg::self_clocked_mode;
            r.active <= clock_gen_pkg::self_clocked_mode;
            r.count  <= 4'h0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign busy_o   = (r.state != clock_gen_pkg::seq_idle);
    assign active_o = r.active;

endmodule // clock_gen_mode_seq

`default_nettype wire

// file: src/clock_gen_config_control.sv
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_consts.svh"

module clock_gen_config_control (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // classic wishbone slave
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic       we_i,
    input  wire logic [7:0] adr_i,
    input  wire logic [3:0] sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]     dat_o,
    output logic            ack_o,
    // system state
    input  wire logic       off_mode_i,
    input  wire logic       stop_enable_i,
    input  wire logic       ext_ref_clock_ready_i,
    // oscillator pins
    input  wire logic       ext_ref_in_pin_i,
    output logic            osc_out_pin_o,
    output logic            osc_out_pin_oe_o,
    // toward the loop and clock tree
    output logic            ext_ref_clock_out_o,
    output logic            osc_enable_o,
    output logic            high_gain_o,
    output logic            range_high_o,
    output logic [6:0]      loop_prescale_o,
    output logic            loss_detect_en_o,
    output logic            dco_free_run_o,
    output logic [1:0]      clock_mode_status_o,
    output logic            ref_kind_status_o
);

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------

    logic [1:0] async_in;
    logic [1:0] sync_in;
    logic       ref_pin_s;
    logic       ref_ready_s;

    assign async_in = {ext_ref_clock_ready_i, ext_ref_in_pin_i};

    // pin and ready flag both come from outside this clock
    clock_gen_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (async_in),
        .sync_o  (sync_in)
    );

    assign ref_pin_s   = sync_in[0];
    assign ref_ready_s = sync_in[1];

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------

    clock_gen_pkg::ctl_regs_t    r;
    clock_gen_pkg::ctl_regs_t    next_r;
    logic                        seq_busy;
    clock_gen_pkg::clock_mode_t  active_mode;

    // -------------------------------------------------------------
    // mode sequencer
    // -------------------------------------------------------------

    clock_gen_mode_seq u_seq (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .req_i    (r.req),
        .mode_i   (r.req_mode),
        .ready_i  (ref_ready_s),
        .busy_o   (seq_busy),
        .active_o (active_mode)
    );

    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------

    logic         bus_req;
    logic         bus_wr;
    logic         hit_ctrl;
    logic         hit_stat;
    logic         mode_pending;
    logic [7:0]   wbyte;
    logic [7:0]   status_byte;
    clock_gen_pkg::clock_mode_t new_mode;

    // a request is taken once; ack drops in the following cycle
    assign bus_req  = cyc_i & stb_i & ~r.ack;
    assign bus_wr   = bus_req & we_i & sel_i[0];
    assign hit_ctrl = (adr_i == `CG_ADDR_CONTROL);
    assign hit_stat = (adr_i == `CG_ADDR_STATUS);
    assign wbyte    = dat_i[7:0];
    assign new_mode = clock_gen_pkg::clock_mode_t'(wbyte[`CG_MODE_HI:`CG_MODE_LO]);

    // a request still in the register stage counts as pending too
    assign mode_pending = seq_busy | r.req;

    // status word seen by software
    always_comb begin
        status_byte = 8'h00;
        status_byte[`CG_ST_MODE_HI:`CG_ST_MODE_LO] = active_mode;
        status_byte[`CG_ST_REF_KIND]   = r.ctrl.ext_ref_select;
        status_byte[`CG_ST_BUSY]       = mode_pending;
        status_byte[`CG_ST_RESERVED]   = r.pins_reserved;
        status_byte[`CG_ST_FIRST_DONE] = r.first_done;
    end

    // -------------------------------------------------------------
    // oscillator decisions
    // -------------------------------------------------------------

    logic ext_mode;
    logic keep_rule;
    logic off_keep;
    logic osc_run;

    // range and the off-mode keep rule matter only while an external mode is requested
    assign ext_mode = r.ctrl.clock_mode_select[1];

    // with high gain and high range the keep bit is treated as clear
    assign keep_rule = r.ctrl.osc_keep_in_off &
                       ~(r.ctrl.high_gain_select & r.ctrl.range_high);

    // off mode: keep bit decides, ref kind must be the crystal
    always_comb begin
        if (keep_rule) begin
            off_keep = ext_mode & r.ctrl.ext_ref_select;
        end else begin
            off_keep = stop_enable_i & r.ctrl.ext_ref_select &
                       (r.ctrl.clock_mode_select == clock_gen_pkg::loop_bypassed_external);
        end
    end

    // never runs on pins that were left to other functions
    assign osc_run = r.pins_reserved & (off_mode_i ? off_keep : 1'b1);

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------

    always_comb begin
        next_r     = r;
        next_r.req = 1'b0;
        next_r.ack = bus_req;

        // read data is captured with the ack; unmapped reads give zero
        if (bus_req) begin
            if (hit_ctrl) begin
                next_r.rdata = {r.ctrl, 1'b0}; // bit 0 reads as zero
            end else if (hit_stat) begin
                next_r.rdata = status_byte;
            end else begin
                next_r.rdata = 8'h00;
            end
        end

        if (bus_wr && hit_ctrl) begin
            next_r.first_done = 1'b1;
            // free bits take every write
            next_r.ctrl.osc_keep_in_off       = wbyte[`CG_BIT_KEEP_OFF];
            next_r.ctrl.clock_loss_detect_off = wbyte[`CG_BIT_LOSS_OFF];

            if (!r.first_done) begin
                // write-once fields are only open before the first write
                next_r.ctrl.high_gain_select = wbyte[`CG_BIT_HIGH_GAIN];
                next_r.ctrl.range_high       = wbyte[`CG_BIT_RANGE];
                next_r.ctrl.ext_ref_select   = wbyte[`CG_BIT_EXT_REF];
                // the pins are claimed once, by the first mode written
                next_r.pins_reserved = new_mode[1];
            end

            // mode change: dropped while pending or toward unclaimed pins
            if (!mode_pending &&
                (!r.first_done || r.pins_reserved || !new_mode[1])) begin
                next_r.ctrl.clock_mode_select = new_mode;
                next_r.req                    = 1'b1;
                next_r.req_mode               = new_mode;
            end
        end

        // off mode itself never touches the mode field
        next_r.osc_enable = osc_run;

        // pin drive follows the oscillator circuit
        next_r.osc_oe      = osc_run;
        next_r.osc_out     = osc_run & r.ctrl.ext_ref_select & ~ref_pin_s;
        next_r.ref_clk_out = osc_run & ref_pin_s;

        // range only steers the loop in the external modes
        next_r.range_eff = r.ctrl.range_high & ext_mode;
        if (next_r.range_eff) begin
            next_r.prescale = `CG_PRESCALE_HIGH;
        end else begin
            next_r.prescale = `CG_PRESCALE_LOW;
        end

        next_r.high_gain      = r.ctrl.high_gain_select;
        next_r.loss_detect_en = ~r.ctrl.clock_loss_detect_off;
        next_r.free_run       = (active_mode == clock_gen_pkg::self_clocked_mode);
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------

    // control reset image; bit 0 has no flop behind it
    localparam logic [7:0] CTRL_RESET = `CG_CONTROL_RESET;

    // reset: low-power gain, self-clocked, pins unclaimed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r                <= '0;
            r.ctrl           <= CTRL_RESET[7:1];
            r.req_mode       <= clock_gen_pkg::self_clocked_mode;
            r.prescale       <= `CG_PRESCALE_LOW;
            r.loss_detect_en <= 1'b1;
            r.free_run       <= 1'b1;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // -------------------------------------------------------------
    // outputs, all straight from flip-flops
    // -------------------------------------------------------------

    assign dat_o               = {24'h000000, r.rdata};
    assign ack_o               = r.ack;
    assign osc_out_pin_o       = r.osc_out;
    assign osc_out_pin_oe_o    = r.osc_oe;
    assign ext_ref_clock_out_o = r.ref_clk_out;
    assign osc_enable_o        = r.osc_enable;
    assign high_gain_o         = r.high_gain;
    assign range_high_o        = r.range_eff;
    assign loop_prescale_o     = r.prescale;
    assign loss_detect_en_o    = r.loss_detect_en;
    assign dco_free_run_o      = r.free_run;
    assign clock_mode_status_o = active_mode;
    assign ref_kind_status_o   = r.ctrl.ext_ref_select;

endmodule // clock_gen_config_control

`default_nettype wire

// file: verification/clock_gen_config_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------
// port checks of the config control
// ---------------------------------------
module clock_gen_config_control_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic        ext_ref_clock_ready_i,
    input wire logic        osc_out_pin_oe_o,
    input wire logic        high_gain_o,
    input wire logic        range_high_o,
    input wire logic [6:0]  loop_prescale_o,
    input wire logic        loss_detect_en_o,
    input wire logic        dco_free_run_o,
    input wire logic [1:0]  clock_mode_status_o,
    input wire logic        ref_kind_status_o
);
    logic       seen;
    logic       first_hi;
    logic [2:0] rdy_run;
    logic       wr_ctl;
    // a control write lands at the edge that raises ack, one edge before the master sees it
    assign wr_ctl = cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00 && sel_i[0];
    // remember whether the first write reserved the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen     <= 1'h0;
            first_hi <= 1'h0;
        end else if (wr_ctl && !seen) begin
            seen     <= 1'h1;
            first_hi <= dat_i[4];
        end
    end
    // ready run length, saturating so it cannot wrap back to zero
    always_ff @(posedge clk_i) begin
        if (rst_i || !ext_ref_clock_ready_i) begin
            rdy_run <= 3'h0;
        end else if (rdy_run != 3'h7) begin
            rdy_run <= rdy_run + 3'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_defaults:
    assert property ($fell(rst_i) |-> !high_gain_o && dco_free_run_o && loss_detect_en_o
        && clock_mode_status_o == 2'h0 && loop_prescale_o == 7'h40) else $error("bad state after reset");
    a_prescale_range:
    assert property (loop_prescale_o == (range_high_o ? 7'h01 : 7'h40)) else $error("prescale off");
    a_pins_unused:
    assert property (seen && !first_hi |-> !osc_out_pin_oe_o) else $error("unreserved pin driven");
    a_no_ext_mode:
    assert property (seen && !first_hi |-> !range_high_o && !clock_mode_status_o[1]) else $error("ext mode");
    a_write_once_bits:
    assert property ($past(seen) |-> $stable(high_gain_o) && $stable(ref_kind_status_o)) else $error("rewrite");
    a_loss_detect_bit:
    assert property (wr_ctl |=> loss_detect_en_o == !$past(dat_i[1])) else $error("loss detect wrong");
    a_bypass_ready:
    assert property ($changed(clock_mode_status_o) && clock_mode_status_o == 2'h2 |-> rdy_run >= 3'h2)
        else $error("bypass without ready");
    a_free_run_mode:
    assert property ($stable(clock_mode_status_o) |-> dco_free_run_o == (clock_mode_status_o == 2'h0))
        else $error("free run wrong");
    a_status_lag_write:
    assert property (wr_ctl && dat_i[4:3] != clock_mode_status_o |=> $stable(clock_mode_status_o))
        else $error("status jumped");
    c_bypass_write: cover property (wr_ctl && dat_i[4:3] == 2'h2);
    c_pin_claimed: cover property ($rose(osc_out_pin_oe_o));
    c_engaged_ext: cover property (clock_mode_status_o == 2'h3);
endmodule // clock_gen_config_control_sva

bind clock_gen_config_control clock_gen_config_control_sva i_sva (.*);
`default_nettype wire

// file: verification/ext_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------
// reference source at the pins
// ---------------------------------------
module ext_ref_model (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      pin_o = 1'h0,
    output logic      ready_o = 1'h0
);
    logic [1:0] div = 2'h0;
    logic [3:0] warm = 4'h0;
    // free toggle; ready only after a warm-up, like a crystal starting
    always @(posedge clk_i) begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        if (div == 2'h2) pin_o <= !pin_o;
        warm <= run_i ? warm + {3'h0, warm != 4'hF} : 4'h0;
        ready_o <= run_i && warm >= 4'h8;
    end
endmodule // ext_ref_model
`default_nettype wire

// file: verification/clock_gen_config_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------
// bench for the config control
// ---------------------------------------
module clock_gen_config_control_tb_top;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        cyc_i = 1'h0;
    logic        stb_i = 1'h0;
    logic        we_i = 1'h0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic        off_mode_i = 1'h0;
    logic        stop_enable_i = 1'h0;
    logic        run = 1'h1;
    logic        ext_ref_clock_ready_i, ext_ref_in_pin_i, ack_o, osc_out_pin_o, osc_out_pin_oe_o;
    logic        ext_ref_clock_out_o, osc_enable_o, high_gain_o, range_high_o, loss_detect_en_o;
    logic        dco_free_run_o, ref_kind_status_o;
    logic [31:0] dat_o;
    logic [6:0]  loop_prescale_o;
    logic [1:0]  clock_mode_status_o, active;
    logic [7:0]  ctrl;
    logic        first, reserved;
    int          mismatches = 0;
    int          n_tests = 0;
    logic [7:0]  firsts[$] = '{8'h08, 8'hF4, 8'h00, 8'h78};

    clock_gen_config_control i_dut (.clk_i, .rst_i, .ce_i(1'h1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .off_mode_i, .stop_enable_i, .ext_ref_clock_ready_i, .ext_ref_in_pin_i,
        .osc_out_pin_o, .osc_out_pin_oe_o, .ext_ref_clock_out_o, .osc_enable_o, .high_gain_o, .range_high_o,
        .loop_prescale_o, .loss_detect_en_o, .dco_free_run_o, .clock_mode_status_o, .ref_kind_status_o);
    ext_ref_model i_src (.clk_i, .run_i(run), .pin_o(ext_ref_in_pin_i), .ready_o(ext_ref_clock_ready_i));

    // 20 MHz clock
    always #25 clk_i = !clk_i;

    task automatic cmp_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_port(input string nm, input logic [6:0] e, input logic [6:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // classic cycle; unused upper data and lanes carry noise the block must ignore
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s0,
                      output logic [31:0] q);
        logic [31:0] r;
        r = $urandom;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {r[31:8], d};
        sel_i <= {r[2:0], s0};
        @(posedge clk_i);
        while (ack_o !== 1'h1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    // pin claim: off mode drops the oscillator unless a keep condition holds
    function automatic logic oe_exp();
        logic keep;
        keep = ctrl[2] && !(ctrl[7] && ctrl[6]);
        if (!off_mode_i) return reserved;
        return reserved && (keep ? ctrl[4] && ctrl[5] : stop_enable_i && ctrl[4:3] == 2'h2 && ctrl[5]);
    endfunction
    task automatic settle();
        logic [31:0] q;
        q = 32'h10;
        for (int i = 0; i < 30 && q[4] !== 1'h0; i++) wb(1'h0, 8'h04, 8'h00, 1'h1, q);
        cmp_bus("pending", 32'h0, {31'h0, q[4]});
    endtask
    task automatic check_all();
        logic [31:0] q;
        logic        re;
        re = ctrl[6] && ctrl[4];
        wb(1'h0, 8'h04, 8'h00, 1'h1, q);
        cmp_bus("status", {24'h0, active, ctrl[5], 3'h0, reserved, first}, q);
        wb(1'h0, 8'h00, 8'h00, 1'h1, q);
        cmp_bus("control", {24'h0, ctrl}, q);
        cmp_port("high_gain", 7'(ctrl[7]), 7'(high_gain_o));
        cmp_port("range", 7'(re), 7'(range_high_o));
        cmp_port("prescale", re ? 7'h01 : 7'h40, loop_prescale_o);
        cmp_port("loss_en", 7'(!ctrl[1]), 7'(loss_detect_en_o));
        cmp_port("free_run", 7'(active == 2'h0), 7'(dco_free_run_o));
        cmp_port("mode_status", 7'(active), 7'(clock_mode_status_o));
        cmp_port("ref_kind", 7'(ctrl[5]), 7'(ref_kind_status_o));
        cmp_port("pin_oe", 7'(oe_exp()), 7'(osc_out_pin_oe_o));
        cmp_port("osc_enable", 7'(oe_exp()), 7'(osc_enable_o));
        cmp_port("osc_out", 7'(oe_exp() && ctrl[5] && !ext_ref_clock_out_o), 7'(osc_out_pin_o));
    endtask
    // model update first, so the later reads have a reference
    task automatic ctl_write(input logic [7:0] d);
        logic [31:0] q;
        if (!first) begin
            ctrl = d & 8'hFE;
            reserved = d[4];
        end else begin
            ctrl[2:1] = d[2:1];
            if (reserved || !d[4]) ctrl[4:3] = d[4:3];
        end
        first = 1'h1;
        active = ctrl[4:3];
        wb(1'h1, 8'h00, d, 1'h1, q);
        settle();
    endtask

    // watchdog far beyond the several hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        close_out();
    end

    initial begin
        logic [31:0] q;
        logic        last;
        int          n;
        void'($urandom(32'h7F7A));
        firsts[2] = 8'($urandom) & 8'hE7;
        foreach (firsts[k]) begin
            rst_i <= 1'h1;
            repeat (12) @(posedge clk_i);
            rst_i <= 1'h0;
            ctrl = 8'h00;
            first = 1'h0;
            reserved = 1'h0;
            active = 2'h0;
            check_all();
            ctl_write(firsts[k]);
            check_all();
            n = 0;
            last = ext_ref_clock_out_o;
            repeat (30) begin
                @(posedge clk_i);
                n += int'(ext_ref_clock_out_o !== last);
                last = ext_ref_clock_out_o;
            end
            cmp_port("ref_clock_runs", 7'(reserved), 7'(n > 2));
            ctl_write(8'($urandom) | 8'h10);
            check_all();
            for (int m = 0; m < 4; m++) begin
                ctl_write({ctrl[7:3], m[0], ctrl[1], 1'h0});
                off_mode_i <= 1'h1;
                stop_enable_i <= m[1];
                check_all();
                off_mode_i <= 1'h0;
            end
            $display("test done: session %0d", k);
        end
        // refusals: unmapped place, low lane off
        wb(1'h1, 8'h08, 8'hFF, 1'h1, q);
        wb(1'h0, 8'h08, 8'h00, 1'h1, q);
        cmp_bus("unmapped", 32'h0, q);
        wb(1'h1, 8'h00, ~ctrl, 1'h0, q);
        ctl_write({ctrl[7:5], 5'h18});
        check_all();
        // bypass held back for ready; a second mode write meanwhile is dropped
        run <= 1'h0;
        repeat (4) @(posedge clk_i);
        wb(1'h1, 8'h00, {ctrl[7:5], 5'h10}, 1'h1, q);
        wb(1'h1, 8'h00, {ctrl[7:5], 5'h0A}, 1'h1, q);
        ctrl[4:1] = 4'h9;
        repeat (20) @(posedge clk_i);
        wb(1'h0, 8'h04, 8'h00, 1'h1, q);
        cmp_bus("status_pending", {24'h0, 2'h3, ctrl[5], 5'h13}, q);
        run <= 1'h1;
        settle();
        active = 2'h2;
        check_all();
        $display("test done: refusals and pending mode");
        close_out();
    end
endmodule // clock_gen_config_control_tb_top
`default_nettype wire
